// File: dv/ecc_port_asserts.sv
// Protocol checks on the serial control link between the host and device ends.
`timescale 1ns/10ps
module ecc_port_asserts (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Link signals.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_rx_pin,
    input wire logic bidir_dev_oe,
    input wire logic bidir_host_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [4:0] rises;

    // ------------------------------------------------------------
    // Session bit counter
    // ------------------------------------------------------------
    // Counting rises per session catches a frame that is one bit short or long.
    always_ff @(posedge clk)
    begin
        if (!resetn || cs_n)
            rises <= 5'h00;
        else if (sclk && !$past(sclk))
            rises <= rises + 5'h01;
    end

    sequence msb_start;
        $fell(cs_n) && !sclk;
    endsequence
    sequence lsb_start;
        $fell(cs_n) && sclk;
    endsequence

    chk_oe_release: assert property (cs_n [*5] |-> !bidir_dev_oe) else $error("pin driven while deselected");
    chk_no_clash: assert property (!(bidir_dev_oe && bidir_host_oe)) else $error("both ends drive pin");
    chk_msb_drive: assert property (msb_start |-> ##[2:8] bidir_dev_oe) else $error("transmit pin idle");
    chk_lsb_quiet: assert property (lsb_start |-> !bidir_dev_oe [*8]) else $error("shared pin taken early");
    chk_rx_stable: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(serial_rx_pin))
        else $error("receive data moved while clock high");
    chk_half_min: assert property ($rose(sclk) |=> sclk [*3]) else $error("clock high phase too short");
    chk_cs_hold: assert property ($fell(cs_n) |=> !cs_n [*8]) else $error("select released early");
    chk_two_bytes: assert property ($rose(cs_n) |-> rises == 5'h10) else $error("session not sixteen bits");
endmodule

// File: dv/tb_echo_canceller_control_port.sv
// Self-checking bench joining the host and device ends over the control link.
`timescale 1ns/10ps
module tb_echo_canceller_control_port import ecc_pkg::*; ;
    typedef struct packed {logic r; logic l; logic [5:0] a; logic [7:0] d;} ecc_row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0, rd = 1'b0, lsb = 1'b0, nproc_pin = 1'b0, law = 1'b0, fmt = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [1:0] straps = 2'h0, st_a = 2'h0, st_b = 2'h0;
    logic busy, done, register_mode, alaw_sel, g711_sel;
    logic [7:0] rdata;
    logic [1:0] atten_en, nproc_en, nb_en, filt_en;
    logic [15:0] dtd;
    ecc_cfg_e cfg;
    ecc_op_e op [2];
    int miscompares = 0, compares = 0;
    // Reads carry the expected byte, writes the byte sent.
    ecc_row_s rows [10] = '{'{1'b1, 1'b0, ADDR_CRB1, CRB1_RST}, '{1'b1, 1'b1, ADDR_CRA1, CRA1_RST},
        '{1'b0, 1'b1, ADDR_CRA2, 8'h1c}, '{1'b1, 1'b0, ADDR_CRA2, 8'h1c}, '{1'b0, 1'b0, ADDR_DTDT1, 8'h5a},
        '{1'b0, 1'b1, ADDR_DTDT2, 8'ha5}, '{1'b1, 1'b1, ADDR_DTDT2, 8'ha5}, '{1'b1, 1'b0, 6'h3f, UNMAPPED_RD},
        '{1'b0, 1'b0, ADDR_CRA1, 8'h20}, '{1'b1, 1'b1, ADDR_CRA1, 8'h20}};
    ecc_port_if port ();
    ecc_device i_ecc_device (.clk(clk), .resetn(resetn), .port(port.dev), .strap_select_a(straps[1]),
        .strap_select_b(straps[0]), .canceller_a_state_pins(st_a), .canceller_b_state_pins(st_b),
        .nonlinear_proc_pin(nproc_pin), .law_pin(law), .format_pin(fmt), .register_mode(register_mode),
        .cfg_mode(cfg), .op_state(op), .atten_en(atten_en), .nonlinear_proc_en(nproc_en),
        .narrowband_detect_en(nb_en), .offset_filter_en(filt_en), .alaw_sel(alaw_sel), .g711_sel(g711_sel),
        .dtd_threshold(dtd));
    ecc_host i_ecc_host (.clk(clk), .resetn(resetn), .port(port.host), .start(start), .read(rd), .lsb_first(lsb),
        .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
    ecc_port_asserts i_ecc_port_asserts (.clk(clk), .resetn(resetn), .cs_n(port.cs_n), .sclk(port.sclk),
        .serial_rx_pin(port.serial_rx_pin), .bidir_dev_oe(port.bidir_dev_oe), .bidir_host_oe(port.bidir_host_oe));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; the wait is bounded so a stuck host cannot hang the run.
    task automatic xfer(input logic r, input logic l, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge clk) #1;
        {rd, lsb, addr, wdata, start} = {r, l, a, d, 1'b1};
        @(posedge clk) #1;
        start = 1'b0;
        check(16'(busy), 16'h1);
        for (n = 0; done !== 1'b1 && n < 400; n++)
            @(posedge clk) #1;
        check(16'({n < 400, busy}), 16'h2);
    endtask

    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial forever #50 clk = ~clk;

    // The run needs about 2100 cycles, so a hang is cut well after that.
    initial
    begin
        #1000000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        foreach (rows[k])
        begin
            xfer(rows[k].r, rows[k].l, rows[k].a, rows[k].d);
            if (rows[k].r)
                check(16'(rdata), 16'(rows[k].d));
        end
        check(16'(register_mode), 16'h1);
        check(16'(cfg), 16'(ECC_CFG_B2B));
        check(dtd, 16'ha55a);
        check(16'({nproc_en[0], nb_en[0], filt_en[0], atten_en[0]}), 16'h0);
        check(16'(op[0]), 16'(ECC_OP_ADAPT));
        $display("register transfers done");
        xfer(1'b0, 1'b0, ADDR_CRA1, 8'h19);
        check(16'({cfg, op[0], atten_en[0]}), 16'({ECC_CFG_CASCADE, ECC_OP_BYPASS, 1'b1}));
        xfer(1'b0, 1'b1, ADDR_CRA1, 8'h04);
        check(16'(op[0]), 16'(ECC_OP_FREEZE));
        xfer(1'b0, 1'b0, ADDR_CRA2, 8'h01);
        check(16'(op[0]), 16'(ECC_OP_MUTE));
        $display("register functions done");
        // Pin control: each strap code also sets opposite state codes on the two cancellers.
        for (int i = 1; i < 4; i++)
        begin
            {straps, st_a, st_b, nproc_pin, law, fmt} = {2'(i), 2'(i), 2'(3 - i), 1'(i >> 1), 1'(i), 1'(i - 1)};
            repeat (6) @(posedge clk);
            #1;
            check(16'(register_mode), 16'h0);
            check(16'(cfg), 16'(i == 1 ? ECC_CFG_CASCADE : (i == 2 ? ECC_CFG_B2B : ECC_CFG_PARALLEL)));
            check(16'({op[0], op[1]}), 16'({2'(i), 2'(3 - i)}));
            check(16'({atten_en, nproc_en, nb_en, filt_en}), 16'({2'h0, {2{1'(i >> 1)}}, 4'hf}));
            check(16'({alaw_sel, g711_sel}), 16'({1'(i), 1'(i - 1)}));
        end
        $display("pin control done");
        // Mid-run reset: outputs and registers fall back to their reset values.
        straps = 2'h0;
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check(16'({register_mode, cfg, op[0]}), 16'({1'b0, ECC_CFG_PARALLEL, ECC_OP_MUTE}));
        resetn = 1'b1;
        xfer(1'b1, 1'b1, ADDR_CRA1, 8'h00);
        check(16'(rdata), 16'(CRA1_RST));
        $display("reset test done");
        report_and_stop();
    end
endmodule

// File: rtl/ecc_device.sv
// Device end of the control port: serial slave, registers and function select.
// How it works
// - Serial port works only when both straps low.
// - Clock high at select: LSB-first, shared pin.
// - Clock low at select: MSB-first, split pins.
// - Host ignores transmit pin while it writes.
// - Receive pin ignored while host reads.
// - Every transfer is command byte plus data.
// - First eight clocks carry command and address.
// - Next eight clocks carry the data byte.
// - Host keeps select low whole transfer.
// - Select high releases the data pin.
// - Data bit order follows the chosen timing.
// - Command: six address bits, unused, direction.
// - Sample on rising, launch on falling clock.
// - Straps pick parallel, back-to-back or cascade.
// - Register bits pick configuration likewise.
// - State pins pick mute, bypass, freeze, adapt.
// - Register bits pick mute, bypass, freeze, adapt.
// - Attenuator off by pins, register enabled.
// - Nonlinear processor: pin enables, bit disables.
// - Narrowband and offset filter: bit disables.
// - Double-talk threshold from two registers.
// - Law and format pins act in both modes.
// - Software never sets back-to-back with cascade.
`timescale 1ns/10ps
module ecc_device
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Serial link.
    ecc_port_if.dev port,
    // Strap and function pins.
    input wire logic strap_select_a,
    input wire logic strap_select_b,
    input wire logic [1:0] canceller_a_state_pins,
    input wire logic [1:0] canceller_b_state_pins,
    input wire logic nonlinear_proc_pin,
    input wire logic law_pin,
    input wire logic format_pin,
    // Resolved operating functions, index 0 is canceller A.
    output logic register_mode,
    output ecc_cfg_e cfg_mode,
    output ecc_op_e op_state [2],
    output logic [1:0] atten_en,
    output logic [1:0] nonlinear_proc_en,
    output logic [1:0] narrowband_detect_en,
    output logic [1:0] offset_filter_en,
    output logic alaw_sel,
    output logic g711_sel,
    output logic [15:0] dtd_threshold
);
    // ----------------------------------------------------------------
    // Input synchronisation and edges
    // ----------------------------------------------------------------
    logic cs_s, sclk_s, bidir_s, rx_s, strap_a_s, strap_b_s, nlp_s, law_s, fmt_s;
    logic [1:0] pins_a_s, pins_b_s;
    logic cs_d, sclk_d;

    ecc_sync #(.W(13)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({port.cs_n, port.sclk, port.serial_tx_or_bidir_pin, port.serial_rx_pin, strap_select_a,
            strap_select_b, canceller_a_state_pins, canceller_b_state_pins, nonlinear_proc_pin, law_pin, format_pin}),
        .q({cs_s, sclk_s, bidir_s, rx_s, strap_a_s, strap_b_s, pins_a_s, pins_b_s, nlp_s, law_s, fmt_s})
    );

    // Previous samples give the edges; select history starts low like the synchroniser, so no false fall.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cs_d <= 1'b0;
            sclk_d <= 1'b0;
        end
        else
        begin
            cs_d <= cs_s;
            sclk_d <= sclk_s;
        end
    end

    logic reg_sel, cs_fall, sclk_rise, sclk_fall;
    assign reg_sel = ({strap_a_s, strap_b_s} == STRAP_REG);
    assign cs_fall = cs_d & ~cs_s;
    assign sclk_rise = ~sclk_d & sclk_s & ~cs_s;
    assign sclk_fall = sclk_d & ~sclk_s & ~cs_s;

    // ----------------------------------------------------------------
    // Serial transfer engine
    // ----------------------------------------------------------------
    logic active, lsb_mode, rd;
    logic [4:0] bit_cnt;
    logic [7:0] rx_shift, cmd, tx_shift;
    logic [7:0] next_rx;
    logic din, commit;

    // Shared pin carries input in LSB-first timing, the separate pin otherwise.
    assign din = lsb_mode ? bidir_s : rx_s;
    assign next_rx = lsb_mode ? {din, rx_shift[7:1]} : {rx_shift[6:0], din};
    assign rd = cmd[CMD_RW];
    // A write lands only on the sixteenth rising edge; an early select rise never gets here.
    assign commit = active & sclk_rise & (bit_cnt == XFER_LAST) & ~rd;

    // Session start, timing choice and bit count.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            active <= 1'b0;
            lsb_mode <= 1'b0;
            bit_cnt <= '0;
        end
        else if (cs_s)
        begin
            active <= 1'b0;
            bit_cnt <= '0;
        end
        else if (cs_fall)
        begin
            active <= reg_sel;
            lsb_mode <= sclk_s;
            bit_cnt <= '0;
        end
        else if (active && sclk_rise && bit_cnt != XFER_END)
        begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Receive shifter; data-phase input is ignored on a read.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_shift <= '0;
            cmd <= '0;
        end
        else if (active && sclk_rise && (bit_cnt < DATA_FIRST || (bit_cnt < XFER_END && !rd)))
        begin
            rx_shift <= next_rx;
            if (bit_cnt == CMD_LAST)
            begin
                cmd <= next_rx;
            end
        end
    end

    // Transmit shifter, loaded as the command completes and launched on falling edges.
    logic tx_bit, tx_oe;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tx_shift <= '0;
            tx_bit <= 1'b0;
        end
        else if (active && sclk_rise && bit_cnt == CMD_LAST)
        begin
            tx_shift <= reg_read(next_rx[ADDR_W-1:0]);
        end
        else if (active && sclk_fall && rd && bit_cnt >= DATA_FIRST && bit_cnt < XFER_END)
        begin
            tx_bit <= lsb_mode ? tx_shift[0] : tx_shift[7];
            tx_shift <= lsb_mode ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
        end
    end

    // Pin drive. The shared pin turns around only at the first launch edge, after the host lets go.
    always_ff @(posedge clk)
    begin
        if (!resetn || cs_s || !active)
        begin
            tx_oe <= 1'b0;
        end
        else if (!lsb_mode)
        begin
            tx_oe <= 1'b1;
        end
        else if (sclk_fall && rd && bit_cnt >= DATA_FIRST)
        begin
            tx_oe <= 1'b1;
        end
    end

    assign port.bidir_dev_out = tx_bit;
    assign port.bidir_dev_oe = tx_oe;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] cr1 [2];
    logic [7:0] cr2 [2];
    logic [7:0] dtdt1, dtdt2;
    logic [5:0] waddr;
    assign waddr = cmd[ADDR_W-1:0];

    function automatic logic [7:0] reg_read(input logic [5:0] a);
        if (a == ADDR_CRA1)
            return cr1[0];
        else if (a == ADDR_CRA2)
            return cr2[0];
        else if (a == ADDR_CRB1)
            return cr1[1];
        else if (a == ADDR_CRB2)
            return cr2[1];
        else if (a == ADDR_DTDT1)
            return dtdt1;
        else if (a == ADDR_DTDT2)
            return dtdt2;
        else
            return UNMAPPED_RD;
    endfunction

    // Writing the reset bit of either first control register restores every register.
    always_ff @(posedge clk)
    begin
        if (!resetn || (commit && (waddr == ADDR_CRA1 || waddr == ADDR_CRB1) && next_rx[CR1_RESET]))
        begin
            cr1[0] <= CRA1_RST;
            cr1[1] <= CRB1_RST;
            cr2[0] <= CR2_RST;
            cr2[1] <= CR2_RST;
            dtdt1 <= DTDT1_RST;
            dtdt2 <= DTDT2_RST;
        end
        else if (commit)
        begin
            if (waddr == ADDR_CRA1)
                cr1[0] <= next_rx & CRA1_WMASK;
            else if (waddr == ADDR_CRA2)
                cr2[0] <= next_rx;
            else if (waddr == ADDR_CRB1)
                cr1[1] <= (next_rx & CRB1_WMASK) | CRB1_RST;
            else if (waddr == ADDR_CRB2)
                cr2[1] <= next_rx;
            else if (waddr == ADDR_DTDT1)
                dtdt1 <= next_rx;
            else if (waddr == ADDR_DTDT2)
                dtdt2 <= next_rx;
        end
    end

    // ----------------------------------------------------------------
    // Function selection
    // ----------------------------------------------------------------
    function automatic ecc_op_e pin_op(input logic [1:0] p);
        case (p)
            PIN_MUTE: return ECC_OP_MUTE;
            PIN_BYPASS: return ECC_OP_BYPASS;
            PIN_FREEZE: return ECC_OP_FREEZE;
            default: return ECC_OP_ADAPT;
        endcase
    endfunction

    function automatic ecc_op_e reg_op(input logic [7:0] c1, input logic [7:0] c2);
        if (c2[CR2_RX_MUTE] || c2[CR2_TX_MUTE])
            return ECC_OP_MUTE;
        else if (c1[CR1_BYPASS])
            return ECC_OP_BYPASS;
        else if (c1[CR1_FREEZE])
            return ECC_OP_FREEZE;
        else
            return ECC_OP_ADAPT;
    endfunction

    // Outputs are registered so downstream sees no decode glitches.
    // If software breaks the exclusive-bit rule, cascade wins over back-to-back.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            register_mode <= 1'b0;
            cfg_mode <= ECC_CFG_PARALLEL;
            op_state[0] <= ECC_OP_MUTE;
            op_state[1] <= ECC_OP_MUTE;
            atten_en <= '0;
            nonlinear_proc_en <= '0;
            narrowband_detect_en <= '0;
            offset_filter_en <= '0;
            alaw_sel <= 1'b0;
            g711_sel <= 1'b0;
            dtd_threshold <= {DTDT2_RST, DTDT1_RST};
        end
        else
        begin
            register_mode <= reg_sel;
            alaw_sel <= law_s;
            g711_sel <= fmt_s;
            if (reg_sel)
            begin
                dtd_threshold <= {dtdt2, dtdt1};
                if (cr1[0][CR1_EXT])
                    cfg_mode <= ECC_CFG_CASCADE;
                else if (cr1[0][CR1_B2B])
                    cfg_mode <= ECC_CFG_B2B;
                else
                    cfg_mode <= ECC_CFG_PARALLEL;
                for (int i = 0; i < 2; i++)
                begin
                    op_state[i] <= reg_op(cr1[i], cr2[i]);
                    atten_en[i] <= cr1[i][CR1_ATTEN];
                    nonlinear_proc_en[i] <= ~cr2[i][CR2_NLP_OFF];
                    narrowband_detect_en[i] <= ~cr2[i][CR2_NB_OFF];
                    offset_filter_en[i] <= ~cr2[i][CR2_HPF_OFF];
                end
            end
            else
            begin
                dtd_threshold <= {DTDT2_RST, DTDT1_RST};
                if ({strap_a_s, strap_b_s} == STRAP_CASCADE)
                    cfg_mode <= ECC_CFG_CASCADE;
                else if ({strap_a_s, strap_b_s} == STRAP_B2B)
                    cfg_mode <= ECC_CFG_B2B;
                else
                    cfg_mode <= ECC_CFG_PARALLEL;
                op_state[0] <= pin_op(pins_a_s);
                op_state[1] <= pin_op(pins_b_s);
                atten_en <= '0;
                nonlinear_proc_en <= {2{nlp_s}};
                narrowband_detect_en <= '1;
                offset_filter_en <= '1;
            end
        end
    end
endmodule

// File: rtl/ecc_host.sv
// Host end of the control port: issues one two-byte register transfer per request.
`timescale 1ns/10ps
module ecc_host
    import ecc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Serial link.
    ecc_port_if.host port,
    // Request.
    input wire logic start,
    input wire logic read,
    input wire logic lsb_first,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    // Answer.
    output logic busy,
    output logic done,
    output logic [7:0] rdata
);
    typedef enum logic [2:0] {H_IDLE, H_PRE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} ecc_hstate_e;
    ecc_hstate_e st;
    logic [2:0] timer;
    logic [3:0] bit_idx;
    logic [15:0] ser;
    logic rd_q, lsb_q, din_s;
    logic cs_n, sclk, dout, oe;

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = b[7-i];
        end
    endfunction

    ecc_sync #(.W(1)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(port.serial_tx_or_bidir_pin),
        .q(din_s)
    );

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    // Host drives on the low half and samples at the end of the high half, which
    // leaves room for both synchroniser delays across the link.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st <= H_IDLE;
            timer <= '0;
            bit_idx <= '0;
            ser <= '0;
            rd_q <= 1'b0;
            lsb_q <= 1'b0;
            cs_n <= 1'b1;
            sclk <= 1'b0;
            dout <= 1'b0;
            oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (timer != '0)
            begin
                timer <= timer - 3'h1;
            end
            else
            begin
                case (st)
                    H_IDLE:
                    begin
                        sclk <= 1'b0;
                        if (start)
                        begin
                            busy <= 1'b1;
                            rd_q <= read;
                            lsb_q <= lsb_first;
                            sclk <= lsb_first;
                            ser <= lsb_first ? {rev8({read, 1'b0, addr}), rev8(wdata)}
                                             : {read, 1'b0, addr, wdata};
                            timer <= HALF_LAST;
                            st <= H_PRE;
                        end
                    end
                    H_PRE:
                    begin
                        cs_n <= 1'b0;
                        dout <= ser[15];
                        oe <= lsb_q;
                        bit_idx <= '0;
                        timer <= HALF_LAST;
                        st <= H_SETUP;
                    end
                    // An idle-high clock must fall before the first rise.
                    H_SETUP:
                    begin
                        sclk <= 1'b0;
                        timer <= HALF_LAST;
                        st <= H_LOW;
                    end
                    H_LOW:
                    begin
                        sclk <= 1'b1;
                        timer <= HALF_LAST;
                        st <= H_HIGH;
                    end
                    H_HIGH:
                    begin
                        if (rd_q && bit_idx >= HBIT_DATA)
                        begin
                            rdata <= lsb_q ? {din_s, rdata[7:1]} : {rdata[6:0], din_s};
                        end
                        timer <= HALF_LAST;
                        if (bit_idx == HBIT_LAST)
                        begin
                            sclk <= lsb_q;
                            st <= H_HOLD;
                        end
                        else
                        begin
                            sclk <= 1'b0;
                            dout <= ser[14];
                            ser <= {ser[14:0], 1'b0};
                            oe <= lsb_q && !(rd_q && bit_idx >= CMD_LAST[3:0]);
                            bit_idx <= bit_idx + 4'h1;
                            st <= H_LOW;
                        end
                    end
                    H_HOLD:
                    begin
                        cs_n <= 1'b1;
                        oe <= 1'b0;
                        timer <= HALF_LAST;
                        st <= H_GAP;
                    end
                    default:
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        st <= H_IDLE;
                    end
                endcase
            end
        end
    end

    assign port.cs_n = cs_n;
    assign port.sclk = sclk;
    assign port.serial_rx_pin = dout;
    assign port.bidir_host_out = dout;
    assign port.bidir_host_oe = oe;
endmodule

// File: rtl/ecc_pkg.sv
// Shared constants and types for the echo canceller control port.
package ecc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);

    // ----------------------------------------------------------------
    // Transfer framing
    // ----------------------------------------------------------------
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] DATA_FIRST = 5'h08;
    localparam logic [4:0] XFER_LAST = 5'h0f;
    localparam logic [4:0] XFER_END = 5'h10;
    localparam logic [3:0] HBIT_DATA = 4'h8;
    localparam logic [3:0] HBIT_LAST = 4'hf;
    localparam int CMD_RW = 7;
    localparam int ADDR_W = 6;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_CRA1 = 6'h00;
    localparam logic [5:0] ADDR_CRA2 = 6'h01;
    localparam logic [5:0] ADDR_DTDT1 = 6'h04;
    localparam logic [5:0] ADDR_DTDT2 = 6'h05;
    localparam logic [5:0] ADDR_CRB1 = 6'h20;
    localparam logic [5:0] ADDR_CRB2 = 6'h21;
    localparam logic [7:0] CRA1_RST = 8'h00;
    localparam logic [7:0] CRB1_RST = 8'h02;
    localparam logic [7:0] CRA1_WMASK = 8'hfd;
    localparam logic [7:0] CRB1_WMASK = 8'hfc;
    localparam logic [7:0] CR2_RST = 8'h00;
    localparam logic [7:0] DTDT1_RST = 8'h00;
    localparam logic [7:0] DTDT2_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

    // Control register 1 fields.
    localparam int CR1_RESET = 7;
    localparam int CR1_INJ_OFF = 6;
    localparam int CR1_B2B = 5;
    localparam int CR1_ATTEN = 4;
    localparam int CR1_BYPASS = 3;
    localparam int CR1_FREEZE = 2;
    localparam int CR1_EXT = 0;
    // Control register 2 fields.
    localparam int CR2_RX_MUTE = 0;
    localparam int CR2_TX_MUTE = 1;
    localparam int CR2_NB_OFF = 2;
    localparam int CR2_HPF_OFF = 3;
    localparam int CR2_NLP_OFF = 4;

    // ----------------------------------------------------------------
    // Strap and state pin codes
    // ----------------------------------------------------------------
    localparam logic [1:0] STRAP_REG = 2'h0;
    localparam logic [1:0] STRAP_CASCADE = 2'h1;
    localparam logic [1:0] STRAP_B2B = 2'h2;
    localparam logic [1:0] PIN_MUTE = 2'h0;
    localparam logic [1:0] PIN_BYPASS = 2'h1;
    localparam logic [1:0] PIN_FREEZE = 2'h2;

    typedef enum logic [1:0] {ECC_CFG_PARALLEL, ECC_CFG_B2B, ECC_CFG_CASCADE} ecc_cfg_e;
    typedef enum logic [1:0] {ECC_OP_MUTE, ECC_OP_BYPASS, ECC_OP_FREEZE, ECC_OP_ADAPT} ecc_op_e;

endpackage

// File: rtl/ecc_port_if.sv
// Serial control link between the host and the echo canceller device.
`timescale 1ns/10ps
interface ecc_port_if;
    logic cs_n;
    logic sclk;
    logic serial_rx_pin;
    logic bidir_dev_out;
    logic bidir_dev_oe;
    logic bidir_host_out;
    logic bidir_host_oe;
    logic serial_tx_or_bidir_pin;

    // Wire level of the shared data pin; an undriven pin floats high by a pull-up.
    assign serial_tx_or_bidir_pin = bidir_dev_oe ? bidir_dev_out : (bidir_host_oe ? bidir_host_out : 1'b1);

    modport dev (input cs_n, sclk, serial_rx_pin, serial_tx_or_bidir_pin, output bidir_dev_out, bidir_dev_oe);
    modport host (input serial_tx_or_bidir_pin, output cs_n, sclk, serial_rx_pin, bidir_host_out, bidir_host_oe);
endinterface

// File: rtl/ecc_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/10ps
module ecc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Asynchronous in, synchronous out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // The first stage is read only by the second.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
